// ### verilog/sevb_pkg.sv
package sevb_pkg;
  // bit positions in the measurement event byte
  localparam int MEV_FRONT_END_OVERLOAD    = 0;
  localparam int MEV_LOWPASS_OVERLOAD      = 1;
  localparam int MEV_OUTPUT_STAGE_OVERLOAD = 2;
  localparam int MEV_REFERENCE_LOST        = 3;
  localparam int MEV_RANGE_SWITCH          = 4;
  localparam int MEV_TC_INDIRECT           = 5;
  localparam int MEV_ARM_EVENT_SEEN        = 6;
  localparam int MEV_PLOT_DONE             = 7;
  // bit positions in the fault byte
  localparam int FLT_HARDCOPY  = 0;
  localparam int FLT_BACKUP    = 1;
  localparam int FLT_RAM       = 2;
  localparam int FLT_DISK      = 3;
  localparam int FLT_ROM       = 4;
  localparam int FLT_STREAM    = 5;
  localparam int FLT_DSP       = 6;
  localparam int FLT_MATH      = 7;
  // reset values and bus address
  localparam logic [7:0] FLAGS_RESET       = 8'h00;
  localparam logic [7:0] ENABLE_RESET      = 8'h00;
  localparam logic [4:0] BUS_ADDR_DEFAULT  = 5'h08;
  localparam logic [7:0] QUERY_DATA_RESET  = 8'h00;
  localparam logic [4:0] TC_EFFECTIVE_RESET = 5'h00;
  localparam logic       BIT_RESET         = 1'h0;
  // detection range thresholds in centihertz
  localparam logic [23:0] RANGE_LOW_CHZ    = 24'h004dd1; // 199.21 Hz
  localparam logic [23:0] RANGE_HIGH_CHZ   = 24'h004f58; // 203.12 Hz
  // longest time constant allowed in the upper range, index form
  localparam logic [4:0] TC_LIMIT_UPPER    = 5'h13;      // 30 s step
endpackage

// ### verilog/sevb_status_bytes.sv
// Contract
// R1 - bit0 set on input or reserve overload
// R2 - bit1 set on lowpass filter overload
// R3 - bit2 set on output stage overload
// R4 - bit3 set on reference lost lock
// R5 - bit4 set on detection range switch
// R6 - upper range limits tc, disables sync filter
// R7 - bit5 set on indirect time constant change
// R8 - bit6 set on trigger when triggered mode
// R9 - bit7 set on plot completion
// R10 - event bits sticky until read or clear
// R11 - fault bit0 on print or plot error
// R12 - fault bit1 on backup failure at power-up
// R13 - fault bit2 on ram test error
// R14 - fault bit3 on disk or file error
// R15 - fault bit4 on rom test error
// R16 - fault bit5 on streaming transfer abort
// R17 - fault bit6 on signal processor test error
// R18 - fault bit7 on internal math error
// R19 - fault bits sticky until read or clear
// R20 - default bus address is eight
// R21 - configuration reset restores address eight
// R22 - byte read clears all, bit read one
// R23 - summary set while flag and enable both set
// R24 - set wins over same-cycle read clear
module sevb_status_bytes (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // measurement event sources, one-cycle pulses or levels
  input  wire logic        front_end_overload,
  input  wire logic        lowpass_overload,
  input  wire logic        output_stage_overload,
  input  wire logic        reference_lost,
  input  wire logic [23:0] detect_freq_chz,
  input  wire logic        tc_indirect_change,
  input  wire logic        trigger_in,
  input  wire logic        triggered_mode,
  input  wire logic        plot_done,
  // fault sources
  input  wire logic        hardcopy_error,
  input  wire logic        backup_failed,
  input  wire logic        ram_test_error,
  input  wire logic        disk_error,
  input  wire logic        rom_test_error,
  input  wire logic        stream_aborted,
  input  wire logic        dsp_test_error,
  input  wire logic        math_error,
  // time constant and filter requests
  input  wire logic [4:0]  tc_request,
  input  wire logic        sync_filter_request,
  output logic [4:0]       tc_effective,
  output logic             sync_filter_on,
  output logic             upper_range,
  // command port from the interface parser
  input  wire logic        event_byte_query,
  input  wire logic        fault_byte_query,
  input  wire logic        query_bit_mode,
  input  wire logic [2:0]  query_bit_index,
  input  wire logic        clear_status,
  input  wire logic        event_enable_we,
  input  wire logic        fault_enable_we,
  input  wire logic [7:0]  enable_wdata,
  output logic [7:0]       query_data,
  output logic             query_valid,
  // summaries and address
  output logic             event_summary,
  output logic             fault_summary,
  input  wire logic        config_reset,
  input  wire logic        addr_we,
  input  wire logic [4:0]  addr_wdata,
  output logic [4:0]       bus_address
);

  logic [7:0]  measurement_event_flags_reg, measurement_event_flags_next;
  logic [7:0]  fault_flags_reg, fault_flags_next;
  logic [7:0]  event_enable_reg, event_enable_next;
  logic [7:0]  fault_enable_reg, fault_enable_next;
  logic [7:0]  query_data_reg, query_data_next;
  logic        query_valid_reg, query_valid_next;
  logic        upper_reg, upper_next;
  logic        range_known_reg, range_known_next;
  logic [4:0]  addr_reg, addr_next;
  logic        backup_seen_reg, backup_seen_next;
  logic [4:0]  tc_effective_reg, tc_effective_next;
  logic        sync_filter_on_reg, sync_filter_on_next;
  logic        event_summary_reg, event_summary_next;
  logic        fault_summary_reg, fault_summary_next;
  logic [7:0]  ev_set, flt_set, ev_clr, flt_clr, sel_mask;

  always_comb begin
    sel_mask = 8'h01 << query_bit_index;
    // upper range above high threshold, lower below low; hysteresis between
    upper_next       = upper_reg;
    range_known_next = 1'h1;
    if (detect_freq_chz > sevb_pkg::RANGE_HIGH_CHZ) begin
      upper_next = 1'h1;
    end else if (detect_freq_chz < sevb_pkg::RANGE_LOW_CHZ) begin
      upper_next = 1'h0;
    end
    ev_set = 8'h00;
    ev_set[sevb_pkg::MEV_FRONT_END_OVERLOAD]    = front_end_overload;    // R1
    ev_set[sevb_pkg::MEV_LOWPASS_OVERLOAD]      = lowpass_overload;      // R2
    ev_set[sevb_pkg::MEV_OUTPUT_STAGE_OVERLOAD] = output_stage_overload; // R3
    ev_set[sevb_pkg::MEV_REFERENCE_LOST]        = reference_lost;        // R4
    // R5
    ev_set[sevb_pkg::MEV_RANGE_SWITCH] = range_known_reg && (upper_next != upper_reg);
    // R7
    ev_set[sevb_pkg::MEV_TC_INDIRECT] = tc_indirect_change ||
                                        (ev_set[sevb_pkg::MEV_RANGE_SWITCH] && upper_next &&
                                         tc_request > sevb_pkg::TC_LIMIT_UPPER);
    ev_set[sevb_pkg::MEV_ARM_EVENT_SEEN] = trigger_in && triggered_mode; // R8
    ev_set[sevb_pkg::MEV_PLOT_DONE]      = plot_done;                   // R9
    flt_set = 8'h00;
    flt_set[sevb_pkg::FLT_HARDCOPY] = hardcopy_error;   // R11
    // only the first cycle after power-up checks the backup memory
    flt_set[sevb_pkg::FLT_BACKUP]   = backup_failed && !backup_seen_reg; // R12
    flt_set[sevb_pkg::FLT_RAM]      = ram_test_error;   // R13
    flt_set[sevb_pkg::FLT_DISK]     = disk_error;       // R14
    flt_set[sevb_pkg::FLT_ROM]      = rom_test_error;   // R15
    flt_set[sevb_pkg::FLT_STREAM]   = stream_aborted;   // R16
    flt_set[sevb_pkg::FLT_DSP]      = dsp_test_error;   // R17
    flt_set[sevb_pkg::FLT_MATH]     = math_error;       // R18
    backup_seen_next = 1'h1;
    // R22
    ev_clr  = 8'h00;
    flt_clr = 8'h00;
    if (event_byte_query) begin
      ev_clr = query_bit_mode ? sel_mask : 8'hff;
    end
    if (fault_byte_query) begin
      flt_clr = query_bit_mode ? sel_mask : 8'hff;
    end
    if (clear_status) begin
      ev_clr  = 8'hff;
      flt_clr = 8'hff;
    end
    // R10 R19 R24
    measurement_event_flags_next = (measurement_event_flags_reg & ~ev_clr) | ev_set;
    fault_flags_next             = (fault_flags_reg & ~flt_clr) | flt_set;
    // answer shows the value before the clear; event query wins if both asked
    query_valid_next = event_byte_query || fault_byte_query;
    query_data_next  = query_data_reg;
    if (event_byte_query) begin
      query_data_next = query_bit_mode ?
        {7'h00, measurement_event_flags_reg[query_bit_index]} : measurement_event_flags_reg;
    end else if (fault_byte_query) begin
      query_data_next = query_bit_mode ?
        {7'h00, fault_flags_reg[query_bit_index]} : fault_flags_reg;
    end
    event_enable_next = event_enable_we ? enable_wdata : event_enable_reg;
    fault_enable_next = fault_enable_we ? enable_wdata : fault_enable_reg;
    addr_next = addr_we ? addr_wdata : addr_reg;
    if (config_reset) begin
      addr_next = sevb_pkg::BUS_ADDR_DEFAULT; // R21
    end
    // limits follow the range of the coming cycle, so the registered outputs
    // never show a long time constant while upper_range is already high
    tc_effective_next = tc_request;
    if (upper_next && tc_request > sevb_pkg::TC_LIMIT_UPPER) begin
      tc_effective_next = sevb_pkg::TC_LIMIT_UPPER; // R6
    end
    sync_filter_on_next = sync_filter_request && !upper_next; // R6
    // built from next values so a summary never lags its flags by a cycle
    event_summary_next = |(measurement_event_flags_next & event_enable_next); // R23
    fault_summary_next = |(fault_flags_next & fault_enable_next);             // R23
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      measurement_event_flags_reg <= sevb_pkg::FLAGS_RESET;
      fault_flags_reg             <= sevb_pkg::FLAGS_RESET;
      event_enable_reg            <= sevb_pkg::ENABLE_RESET;
      fault_enable_reg            <= sevb_pkg::ENABLE_RESET;
      query_data_reg              <= sevb_pkg::QUERY_DATA_RESET;
      query_valid_reg             <= sevb_pkg::BIT_RESET;
      upper_reg                   <= sevb_pkg::BIT_RESET;
      range_known_reg             <= sevb_pkg::BIT_RESET;
      addr_reg                    <= sevb_pkg::BUS_ADDR_DEFAULT; // R20
      backup_seen_reg             <= sevb_pkg::BIT_RESET;
      tc_effective_reg            <= sevb_pkg::TC_EFFECTIVE_RESET;
      sync_filter_on_reg          <= sevb_pkg::BIT_RESET;
      event_summary_reg           <= sevb_pkg::BIT_RESET;
      fault_summary_reg           <= sevb_pkg::BIT_RESET;
    end else begin
      measurement_event_flags_reg <= measurement_event_flags_next;
      fault_flags_reg             <= fault_flags_next;
      event_enable_reg            <= event_enable_next;
      fault_enable_reg            <= fault_enable_next;
      query_data_reg              <= query_data_next;
      query_valid_reg             <= query_valid_next;
      upper_reg                   <= upper_next;
      range_known_reg             <= range_known_next;
      addr_reg                    <= addr_next;
      backup_seen_reg             <= backup_seen_next;
      tc_effective_reg            <= tc_effective_next;
      sync_filter_on_reg          <= sync_filter_on_next;
      event_summary_reg           <= event_summary_next;
      fault_summary_reg           <= fault_summary_next;
    end
  end

  assign tc_effective   = tc_effective_reg;
  assign sync_filter_on = sync_filter_on_reg;
  assign upper_range    = upper_reg;
  assign query_data     = query_data_reg;
  assign query_valid    = query_valid_reg;
  assign bus_address    = addr_reg;
  assign event_summary  = event_summary_reg;
  assign fault_summary  = fault_summary_reg;

  // stickiness, set over clear, byte reads, trigger gate, limits, address and summary
  a_event_sticky: assert property (@(posedge clk) disable iff (reset) // R10
    (front_end_overload && !clear_status) |=> measurement_event_flags_reg[0])
    else $error("overload flag not set");
  a_event_hold: assert property (@(posedge clk) disable iff (reset) // R10
    (measurement_event_flags_reg[3] && !event_byte_query && !clear_status)
      |=> measurement_event_flags_reg[3])
    else $error("event flag dropped without clear");
  a_fault_hold: assert property (@(posedge clk) disable iff (reset) // R19
    (fault_flags_reg[7] && !fault_byte_query && !clear_status) |=> fault_flags_reg[7])
    else $error("fault flag dropped without clear");
  a_set_wins: assert property (@(posedge clk) disable iff (reset) // R24
    (event_byte_query && plot_done) |=> measurement_event_flags_reg[7])
    else $error("event lost on read");
  a_byte_clear: assert property (@(posedge clk) disable iff (reset) // R22
    (fault_byte_query && !query_bit_mode && flt_set == 8'h00) |=> fault_flags_reg == 8'h00)
    else $error("byte read did not clear");
  a_read_data: assert property (@(posedge clk) disable iff (reset) // R22
    (event_byte_query && !query_bit_mode)
      |=> query_valid && query_data == $past(measurement_event_flags_reg))
    else $error("query data wrong");
  a_arm_event_seen_gate: assert property (@(posedge clk) disable iff (reset) // R8
    (!measurement_event_flags_reg[6] && !triggered_mode) |=> !measurement_event_flags_reg[6])
    else $error("trigger flag set while untriggered");
  a_upper_limit: assert property (@(posedge clk) disable iff (reset) // R6
    upper_range |-> (tc_effective <= sevb_pkg::TC_LIMIT_UPPER) && !sync_filter_on)
    else $error("upper range limits broken");
  a_addr_restore: assert property (@(posedge clk) disable iff (reset) // R21
    config_reset |=> bus_address == sevb_pkg::BUS_ADDR_DEFAULT)
    else $error("address not restored");
  a_summary_set: assert property (@(posedge clk) disable iff (reset) // R23
    (measurement_event_flags_reg[0] && event_enable_reg[0]) |-> event_summary)
    else $error("event summary missing");

  // per-bit sources
  a_arm_event_seen_set: assert property (@(posedge clk) disable iff (reset) // R8
    (trigger_in && triggered_mode) |=> measurement_event_flags_reg[6])
    else $error("trigger flag not set");
  a_plot_set: assert property (@(posedge clk) disable iff (reset) // R9
    plot_done |=> measurement_event_flags_reg[7])
    else $error("plot flag not set");
  a_unlock_set: assert property (@(posedge clk) disable iff (reset) // R4
    reference_lost |=> measurement_event_flags_reg[3])
    else $error("unlock flag not set");
  a_stream_set: assert property (@(posedge clk) disable iff (reset) // R16
    stream_aborted |=> fault_flags_reg[5])
    else $error("stream abort flag not set");
  a_backup_once: assert property (@(posedge clk) disable iff (reset) // R12
    (backup_seen_reg && !fault_flags_reg[1]) |=> !fault_flags_reg[1])
    else $error("backup flag set after power-up");

  // reads, clears and answers
  a_bit_clear: assert property (@(posedge clk) disable iff (reset) // R22
    (event_byte_query && query_bit_mode && !clear_status && ev_set == 8'h00)
      |=> measurement_event_flags_reg == ($past(measurement_event_flags_reg) & ~$past(sel_mask)))
    else $error("bit read cleared wrong bits");
  a_clear_all: assert property (@(posedge clk) disable iff (reset) // R10
    (clear_status && ev_set == 8'h00 && flt_set == 8'h00)
      |=> measurement_event_flags_reg == 8'h00 && fault_flags_reg == 8'h00)
    else $error("clear did not empty the bytes");
  a_fault_data: assert property (@(posedge clk) disable iff (reset) // R22
    (fault_byte_query && !event_byte_query && !query_bit_mode)
      |=> query_valid && query_data == $past(fault_flags_reg))
    else $error("fault query data wrong");
  a_bit_data: assert property (@(posedge clk) disable iff (reset) // R22
    (event_byte_query && query_bit_mode) |=> query_data[7:1] == 7'h00 &&
      query_data[0] == |($past(measurement_event_flags_reg) & $past(sel_mask)))
    else $error("bit query data wrong");
  a_valid_pulse: assert property (@(posedge clk) disable iff (reset) // R22
    (!event_byte_query && !fault_byte_query) |=> !query_valid)
    else $error("answer without query");

  // range, limits, summaries and address
  a_range_up: assert property (@(posedge clk) disable iff (reset) // R5
    (detect_freq_chz > sevb_pkg::RANGE_HIGH_CHZ) |=> upper_range)
    else $error("upper range not entered");
  a_range_down: assert property (@(posedge clk) disable iff (reset) // R5
    (detect_freq_chz < sevb_pkg::RANGE_LOW_CHZ) |=> !upper_range)
    else $error("upper range not left");
  a_range_hold: assert property (@(posedge clk) disable iff (reset) // R5
    (detect_freq_chz >= sevb_pkg::RANGE_LOW_CHZ && detect_freq_chz <= sevb_pkg::RANGE_HIGH_CHZ)
      |=> $stable(upper_range))
    else $error("range moved inside the band");
  a_range_flag: assert property (@(posedge clk) disable iff (reset) // R5
    (range_known_reg && !upper_range && detect_freq_chz > sevb_pkg::RANGE_HIGH_CHZ)
      |=> measurement_event_flags_reg[4])
    else $error("range switch flag not set");
  a_tc_range: assert property (@(posedge clk) disable iff (reset) // R7
    (range_known_reg && !upper_range && detect_freq_chz > sevb_pkg::RANGE_HIGH_CHZ &&
     tc_request > sevb_pkg::TC_LIMIT_UPPER) |=> measurement_event_flags_reg[5])
    else $error("indirect time constant flag not set");
  a_fault_summary: assert property (@(posedge clk) disable iff (reset) // R23
    (fault_flags_reg == 8'h00) |-> !fault_summary)
    else $error("fault summary without flags");
  a_addr_hold: assert property (@(posedge clk) disable iff (reset) // R20
    (!addr_we && !config_reset) |=> $stable(bus_address))
    else $error("address moved without write");

endmodule

// ### tb/sevb_host_model.sv
module sevb_host_model (
  // clock and answer
  input  wire logic       clk,
  input  wire logic [7:0] query_data,
  input  wire logic       query_valid,
  // query and clear strobes
  output logic            event_byte_query,
  output logic            fault_byte_query,
  output logic            query_bit_mode,
  output logic [2:0]      query_bit_index,
  output logic            clear_status
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {event_byte_query, fault_byte_query, query_bit_mode, clear_status} = 4'h0;
    query_bit_index = 3'h0;
  end
  // index flipped once released, so a stale index cannot pass for a good one
  task automatic read(input bit flt, input bit bm, input logic [2:0] idx,
                      output logic [7:0] data, output logic ok);
    @(posedge clk);
    #1 {event_byte_query, fault_byte_query, query_bit_mode} = {!flt, flt, bm};
    query_bit_index = idx;
    @(posedge clk);
    #1 {event_byte_query, fault_byte_query, query_bit_mode} = 3'h0;
    query_bit_index = ~idx;
    data = query_data;
    ok = query_valid;
  endtask
  task automatic clear();
    @(posedge clk);
    #1 clear_status = 1'b1;
    @(posedge clk);
    #1 clear_status = 1'b0;
  endtask
endmodule

// ### tb/sevb_status_bytes_tb.sv
module sevb_status_bytes_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, reset, triggered_mode, backup_failed, config_reset, addr_we, sync_filter_request;
  logic event_enable_we, fault_enable_we, query_valid, event_byte_query, fault_byte_query;
  logic query_bit_mode, clear_status, upper_range, sync_filter_on, event_summary, fault_summary;
  logic [7:0]  ev_in, ft_in, enable_wdata, query_data;
  logic [7:0]  m [2];
  logic [2:0]  query_bit_index;
  logic [4:0]  tc_request, tc_effective, addr_wdata, bus_address;
  logic [23:0] detect_freq_chz;
  wire logic front_end_overload, lowpass_overload, output_stage_overload, reference_lost;
  wire logic tc_indirect_change, trigger_in, plot_done, hardcopy_error, ram_test_error;
  wire logic disk_error, rom_test_error, stream_aborted, dsp_test_error, math_error;
  int miscompares, check_count, cycles, seed, r;
  assign {plot_done, trigger_in, tc_indirect_change, reference_lost, output_stage_overload,
          lowpass_overload, front_end_overload} = {ev_in[7:5], ev_in[3:0]};
  assign {math_error, dsp_test_error, stream_aborted, rom_test_error, disk_error,
          ram_test_error, hardcopy_error} = {ft_in[7:2], ft_in[0]};
  sevb_status_bytes dut (.clk, .reset, .front_end_overload, .lowpass_overload,
    .output_stage_overload, .reference_lost, .detect_freq_chz, .tc_indirect_change, .trigger_in,
    .triggered_mode, .plot_done, .hardcopy_error, .backup_failed, .ram_test_error, .disk_error,
    .rom_test_error, .stream_aborted, .dsp_test_error, .math_error, .tc_request,
    .sync_filter_request, .tc_effective, .sync_filter_on, .upper_range, .event_byte_query,
    .fault_byte_query, .query_bit_mode, .query_bit_index, .clear_status, .event_enable_we,
    .fault_enable_we, .enable_wdata, .query_data, .query_valid, .event_summary, .fault_summary,
    .config_reset, .addr_we, .addr_wdata, .bus_address);
  sevb_host_model host (.clk, .query_data, .query_valid, .event_byte_query, .fault_byte_query,
    .query_bit_mode, .query_bit_index, .clear_status);
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_bit(input string what, input logic exp, input logic got);
    chk_byte(what, {7'h0, exp}, {7'h0, got});
  endtask
  // sources pulse in the very cycle the read is taken, so set-over-clear is hit on the reads given nonzero sources
  task automatic xfer(input bit flt, input bit bm, input logic [2:0] idx,
                      input logic [7:0] ev, input logic [7:0] ft);
    logic [7:0] d, old;
    logic ok;
    old = m[flt];
    fork
      host.read(flt, bm, idx, d, ok);
      begin
        @(posedge clk);
        #1 {ev_in, ft_in} = {ev, ft};
        @(posedge clk);
        #1 {ev_in, ft_in} = 16'h0;
      end
    join
    chk_bit("query_valid", 1'b1, ok);
    chk_byte("query_data", bm ? {7'h0, old[idx]} : old, d);
    if (bm) m[flt][idx] = 1'b0;
    else m[flt] = 8'h00;
    m[0] = m[0] | (triggered_mode ? ev : ev & 8'hbf);
    m[1] = m[1] | ft;
  endtask
  initial begin
    seed = 77492;
    {reset, backup_failed, triggered_mode, config_reset, addr_we, sync_filter_request} = 6'h31;
    {event_enable_we, fault_enable_we, ev_in, ft_in, enable_wdata, addr_wdata} = 31'h0;
    {detect_freq_chz, tc_request} = {24'h004e20, 5'h05};
    repeat (10) @(posedge clk);
    #1 reset = 1'b0;
    @(posedge clk);
    #1 backup_failed = 1'b0;
    chk_byte("bus_address", 8'h08, {3'h0, bus_address});
    {m[0], m[1]} = 16'h0002;
    xfer(1'b1, 1'b0, 3'h0, 8'h00, 8'h00);
    repeat (60) begin
      r = $random(seed);
      triggered_mode = r[24];
      xfer(r[0], r[1], r[4:2], r[15:8] & 8'hef, r[23:16] & 8'hfd);
    end
    host.clear();
    {m[0], m[1]} = 16'h0;
    xfer(1'b0, 1'b0, 3'h0, 8'h00, 8'h00);
    xfer(1'b1, 1'b0, 3'h0, 8'h00, 8'h00);
    // up past the high threshold with a long time constant asked, then down past the low one
    {tc_request, detect_freq_chz} = {5'h1f, 24'h004f59};
    repeat (3) @(posedge clk);
    #1 chk_bit("upper_range", 1'h1, upper_range);
    chk_byte("tc_effective", 8'h13, {3'h0, tc_effective});
    chk_bit("sync_filter_on", 1'h0, sync_filter_on);
    m[0][5:4] = 2'h3;
    xfer(1'h0, 1'h0, 3'h0, 8'h00, 8'h00);
    {tc_request, detect_freq_chz} = {5'h05, 24'h004dd0};
    repeat (3) @(posedge clk);
    #1 chk_bit("sync_filter_on", 1'h1, sync_filter_on);
    chk_byte("tc_effective", 8'h05, {3'h0, tc_effective});
    m[0][4] = 1'b1;
    xfer(1'b0, 1'b0, 3'h0, 8'h00, 8'h00);
    {enable_wdata, event_enable_we, fault_enable_we} = {8'h01, 2'h3};
    @(posedge clk);
    #1 {event_enable_we, fault_enable_we, ev_in, ft_in} = {2'h0, 8'h01, 8'h01};
    @(posedge clk);
    #1 {ev_in, ft_in} = 16'h0;
    chk_bit("event_summary", 1'b1, event_summary);
    {m[0], m[1]} = 16'h0101;
    xfer(1'b0, 1'b0, 3'h0, 8'h00, 8'h00);
    chk_bit("event_summary", 1'b0, event_summary);
    chk_bit("fault_summary", 1'b1, fault_summary);
    {addr_wdata, addr_we} = {5'h03, 1'b1};
    @(posedge clk);
    #1 {addr_we, config_reset} = 2'h1;
    chk_byte("bus_address", 8'h03, {3'h0, bus_address});
    @(posedge clk);
    #1 config_reset = 1'b0;
    chk_byte("bus_address", 8'h08, {3'h0, bus_address});
    report_and_stop();
  end
endmodule
